// File: pbr_config_header.sv
`timescale 1ns/100ps
// Operation
// - Device-select timing field reads fixed medium-speed code 01.
// - Software writes to status never set an event flag.
// - Parity error detected sets bit 31 until software clears it.
// - Asserting the system-error pin sets bit 30.
// - Master abort on own transaction sets bit 29.
// - Target abort received as master sets bit 28.
// - Target abort signalled as target sets bit 27.
// - Driving or observing the parity-error pin sets bit 24.
// - Command bits 8, 6, 2, 1, 0 enable their functions when one.
// - Reserved bits 22 to 10 read zero; software writes zeros.
// - Class code reads host-bridge base class, zero subclass and interface.
// - Low byte of class word is a revision code set per silicon.
// - Latency timer in bits 15:8 with low three bits reading zero.
// - Cache line size reads fixed four.
// - Mailbox base keeps bits 31:11; bits 10:4 zero for 2 KB.
// - Base registers read memory space and anywhere-in-32-bit type.
// - Window one base bits 20:4 read zero.
// - Window one bits 27:21 store written value ANDed with mask.
// - Window two behaves like window one with its own mask.
// - Command is the low halfword, status the high halfword.
// - Registers are reached only through the internal I/O space.
module pbr_config_header #(
    parameter logic [7:0] REVISION_CODE = 8'h00 // Arbitrary value.
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input pbr_pkg::pbr_reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic parity_err_i,
    input wire logic serr_request_i,
    input wire logic master_abort_i,
    input wire logic target_abort_rx_i,
    input wire logic target_abort_tx_i,
    input wire logic perr_observed_i,
    input wire logic [6:0] window1_mask_i,
    input wire logic [6:0] window2_mask_i,
    output pbr_pkg::pbr_cmd_t cmd_o,
    output logic serr_drive_o,
    output logic perr_drive_o,
    output logic [31:0] mailbox_base_o,
    output logic [31:0] window1_base_o,
    output logic [31:0] window2_base_o
);

    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] lat;
        logic [31:0] mailbox;
        logic [31:0] rdata;
        logic rvalid;
        logic serr_drive;
        logic perr_drive;
    } pbr_main_state_t;

    pbr_main_state_t r;
    pbr_main_state_t next_r;
    pbr_pkg::pbr_events_t flags;
    pbr_pkg::pbr_events_t ev_set;
    pbr_pkg::pbr_events_t ev_clr;
    logic wr_cmd;
    logic rd_cmd;
    logic rd_class;
    logic rd_lat;
    logic wr_win1;
    logic wr_win2;

    // True when a request of the given kind hits the given address.
    function automatic logic hit(input logic strobe, input logic [31:0] addr,
        input logic [31:0] target);
        hit = strobe && (addr == target);
    endfunction : hit

    // Builds the status halfword above the command halfword.
    function automatic logic [31:0] cmd_status_word(input pbr_pkg::pbr_events_t ev,
        input logic [31:0] cmd);
        logic [31:0] w;
        w = cmd & pbr_pkg::CMD_WRITABLE;
        w[pbr_pkg::DPE_POS] = ev.parity_err_detected_flag;
        w[pbr_pkg::SSE_POS] = ev.sys_err_signalled_flag;
        w[pbr_pkg::RMA_POS] = ev.master_abort_received_flag;
        w[pbr_pkg::RTA_POS] = ev.target_abort_received_flag;
        w[pbr_pkg::STA_POS] = ev.target_abort_signalled_flag;
        w[pbr_pkg::DEVSEL_LSB +: 2] = pbr_pkg::DEVSEL_MEDIUM;
        w[pbr_pkg::DPR_POS] = ev.data_parity_reported_flag;
        cmd_status_word = w;
    endfunction : cmd_status_word

    // Decodes the internal I/O space accesses; nothing else reaches these.
    assign wr_cmd = hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::CMD_STATUS_ADDR);
    assign rd_cmd = hit(reg_req_i.rd, reg_req_i.addr, pbr_pkg::CMD_STATUS_ADDR);
    assign rd_class = hit(reg_req_i.rd, reg_req_i.addr, pbr_pkg::REV_CLASS_ADDR);
    assign rd_lat = hit(reg_req_i.rd, reg_req_i.addr, pbr_pkg::LINE_LAT_ADDR);
    assign wr_win1 = hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::WINDOW1_BASE_ADDR);
    assign wr_win2 = hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::WINDOW2_BASE_ADDR);

    // Bus events that set the status flags.
    always_comb
    begin
        ev_set.parity_err_detected_flag = parity_err_i;
        ev_set.sys_err_signalled_flag = r.serr_drive;
        ev_set.master_abort_received_flag = master_abort_i;
        ev_set.target_abort_received_flag = target_abort_rx_i;
        ev_set.target_abort_signalled_flag = target_abort_tx_i;
        ev_set.data_parity_reported_flag = r.perr_drive | perr_observed_i;
    end

    // Software clears flags by writing ones to the status byte only.
    always_comb
    begin
        ev_clr = '0;
        if (wr_cmd && reg_req_i.be[3])
        begin
            ev_clr.parity_err_detected_flag = reg_req_i.wdata[pbr_pkg::DPE_POS];
            ev_clr.sys_err_signalled_flag = reg_req_i.wdata[pbr_pkg::SSE_POS];
            ev_clr.master_abort_received_flag = reg_req_i.wdata[pbr_pkg::RMA_POS];
            ev_clr.target_abort_received_flag = reg_req_i.wdata[pbr_pkg::RTA_POS];
            ev_clr.target_abort_signalled_flag = reg_req_i.wdata[pbr_pkg::STA_POS];
            ev_clr.data_parity_reported_flag = reg_req_i.wdata[pbr_pkg::DPR_POS];
        end
    end

    // Status flags: writes reach only the clear input, never the set.
    pbr_sticky_flags #(
        .WIDTH(pbr_pkg::EVENT_COUNT)
    ) u_flags (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .set_i(ev_set),
        .clr_i(ev_clr),
        .flags_o(flags)
    );

    // Target window 1 base.
    pbr_window_base u_window1 (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wr_i(wr_win1),
        .be_i(reg_req_i.be),
        .wdata_i(reg_req_i.wdata),
        .mask_i(window1_mask_i),
        .base_o(window1_base_o)
    );

    // Target window 2 base, masked by its own translation field.
    pbr_window_base u_window2 (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wr_i(wr_win2),
        .be_i(reg_req_i.be),
        .wdata_i(reg_req_i.wdata),
        .mask_i(window2_mask_i),
        .base_o(window2_base_o)
    );

    // Register writes, read return and gated error pin drives.
    always_comb
    begin
        next_r = r;
        next_r.rvalid = reg_req_i.rd;
        next_r.rdata = '0;
        if (wr_cmd)
        begin
            next_r.cmd = pbr_pkg::pbr_merge(r.cmd, reg_req_i.wdata, reg_req_i.be,
                pbr_pkg::CMD_WRITABLE);
        end
        if (hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::LINE_LAT_ADDR))
        begin
            next_r.lat = pbr_pkg::pbr_merge(r.lat, reg_req_i.wdata, reg_req_i.be,
                pbr_pkg::LAT_WRITABLE);
        end
        if (hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::MAILBOX_BASE_ADDR))
        begin
            next_r.mailbox = pbr_pkg::pbr_merge(r.mailbox, reg_req_i.wdata, reg_req_i.be,
                pbr_pkg::MAILBOX_WRITABLE);
        end
        if (rd_cmd)
        begin
            next_r.rdata = cmd_status_word(flags, r.cmd);
        end
        else if (rd_class)
        begin
            next_r.rdata = {pbr_pkg::BASE_CLASS_BRIDGE, pbr_pkg::SUB_CLASS_VALUE,
                pbr_pkg::IFACE_CODE_VALUE, REVISION_CODE};
        end
        else if (rd_lat)
        begin
            next_r.rdata = r.lat | {24'h00_0000, pbr_pkg::CACHE_LINE_VALUE};
        end
        else if (hit(reg_req_i.rd, reg_req_i.addr, pbr_pkg::MAILBOX_BASE_ADDR))
        begin
            next_r.rdata = mailbox_base_o;
        end
        else if (hit(reg_req_i.rd, reg_req_i.addr, pbr_pkg::WINDOW1_BASE_ADDR))
        begin
            next_r.rdata = window1_base_o;
        end
        else if (hit(reg_req_i.rd, reg_req_i.addr, pbr_pkg::WINDOW2_BASE_ADDR))
        begin
            next_r.rdata = window2_base_o;
        end
        next_r.serr_drive = serr_request_i && r.cmd[pbr_pkg::SYS_ERROR_REPORT_ENABLE_POS];
        next_r.perr_drive = parity_err_i && r.cmd[pbr_pkg::PER_POS];
    end

    // State register.
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '{cmd: pbr_pkg::CMD_RESET, lat: pbr_pkg::LAT_RESET,
                mailbox: pbr_pkg::MAILBOX_RESET, rdata: 32'h0000_0000,
                rvalid: 1'b0, serr_drive: 1'b0, perr_drive: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    // Enables and drives toward the bus logic.
    assign cmd_o.sys_error_report_enable = r.cmd[pbr_pkg::SYS_ERROR_REPORT_ENABLE_POS];
    assign cmd_o.parity_response_enable = r.cmd[pbr_pkg::PER_POS];
    assign cmd_o.bus_master_enable = r.cmd[pbr_pkg::BUS_MASTER_ENABLE_POS];
    assign cmd_o.memory_decode_enable = r.cmd[pbr_pkg::MEMORY_DECODE_ENABLE_POS];
    assign cmd_o.io_decode_enable = r.cmd[pbr_pkg::IO_DECODE_ENABLE_POS];
    assign serr_drive_o = r.serr_drive;
    assign perr_drive_o = r.perr_drive;
    assign reg_rdata_o = r.rdata;
    assign reg_rvalid_o = r.rvalid;
    assign mailbox_base_o = {r.mailbox[31:4], pbr_pkg::MAILBOX_LOW_BITS};

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_devsel;
        rd_cmd |=> (reg_rdata_o[26:25] == pbr_pkg::DEVSEL_MEDIUM) && reg_rvalid_o;
    endproperty
    a_devsel: assert property (p_devsel) else $error("Timing field not medium.");

    property p_no_sw_set;
        ##1 (((flags & ~$past(flags)) & ~$past(ev_set)) == '0);
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("Flag set without event.");

    property p_w1c;
        (wr_cmd && reg_req_i.be[3] && reg_req_i.wdata[pbr_pkg::DPE_POS] && !parity_err_i)
        |=> !flags.parity_err_detected_flag;
    endproperty
    a_w1c: assert property (p_w1c) else $error("Write of one did not clear.");

    property p_hold;
        (flags.parity_err_detected_flag && !ev_clr.parity_err_detected_flag)
        |=> flags.parity_err_detected_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("Parity flag lost.");

    property p_dpe;
        parity_err_i |=> flags.parity_err_detected_flag;
    endproperty
    a_dpe: assert property (p_dpe) else $error("Parity error not recorded.");

    property p_sse;
        serr_drive_o |=> flags.sys_err_signalled_flag;
    endproperty
    a_sse: assert property (p_sse) else $error("System error not recorded.");

    property p_rma;
        master_abort_i |=> flags.master_abort_received_flag;
    endproperty
    a_rma: assert property (p_rma) else $error("Master abort not recorded.");

    property p_rta;
        target_abort_rx_i |=> flags.target_abort_received_flag;
    endproperty
    a_rta: assert property (p_rta) else $error("Target abort not recorded.");

    property p_sta;
        target_abort_tx_i |=> flags.target_abort_signalled_flag;
    endproperty
    a_sta: assert property (p_sta) else $error("Signalled abort not recorded.");

    property p_dpr;
        (perr_drive_o || perr_observed_i) |=> flags.data_parity_reported_flag;
    endproperty
    a_dpr: assert property (p_dpr) else $error("Parity report not recorded.");

    property p_serr_gate;
        serr_drive_o |-> $past(cmd_o.sys_error_report_enable) && $past(serr_request_i);
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("Pin driven while off.");

    property p_reserved;
        rd_cmd |=> (reg_rdata_o[23:9] == 15'h0000) && (reg_rdata_o[7] == 1'b0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits not zero.");

    property p_class;
        rd_class |=> (reg_rdata_o == {24'h06_0000, REVISION_CODE});
    endproperty
    a_class: assert property (p_class) else $error("Class word wrong.");

    property p_lat;
        rd_lat |=> (reg_rdata_o[10:0] == 11'h004) && (reg_rdata_o[31:16] == 16'h0000);
    endproperty
    a_lat: assert property (p_lat) else $error("Line size or timer low bits wrong.");

    property p_bases;
        (mailbox_base_o[10:0] == 11'h000) && (window1_base_o[20:0] == 21'h00_0008)
        && (window2_base_o[20:0] == 21'h00_0008);
    endproperty
    a_bases: assert property (p_bases) else $error("Base low bits wrong.");

    property p_perr_gate;
        perr_drive_o |-> $past(cmd_o.parity_response_enable) && $past(parity_err_i);
    endproperty
    a_perr_gate: assert property (p_perr_gate) else $error("Parity pin driven while off.");

    property p_cmd_hold;
        !wr_cmd |=> (r.cmd == $past(r.cmd));
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("Command changed without write.");

    property p_sse_cause;
        $rose(flags.sys_err_signalled_flag) |-> $past(serr_drive_o);
    endproperty
    a_sse_cause: assert property (p_sse_cause) else $error("System error flag without drive.");

    property p_cmd_store;
        (wr_cmd && reg_req_i.be[0]) |=> (cmd_o.memory_decode_enable == $past(reg_req_i.wdata[1]));
    endproperty
    a_cmd_store: assert property (p_cmd_store) else $error("Command halfword not stored.");

    property p_mailbox_store;
        (hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::MAILBOX_BASE_ADDR) && reg_req_i.be[3])
        |=> (mailbox_base_o[31:24] == $past(reg_req_i.wdata[31:24]));
    endproperty
    a_mailbox_store: assert property (p_mailbox_store) else $error("Mailbox base not stored.");

    property p_lat_store;
        (hit(reg_req_i.wr, reg_req_i.addr, pbr_pkg::LINE_LAT_ADDR) && reg_req_i.be[1])
        |=> (r.lat[15:8] == ($past(reg_req_i.wdata[15:8]) & 8'hF8));
    endproperty
    a_lat_store: assert property (p_lat_store) else $error("Latency timer not stored.");

endmodule : pbr_config_header

// File: pbr_pkg.sv
package pbr_pkg;

    // Register addresses in the internal I/O space.
    localparam logic [31:0] CMD_STATUS_ADDR = 32'h0F00_0D04;
    localparam logic [31:0] REV_CLASS_ADDR = 32'h0F00_0D08;
    localparam logic [31:0] LINE_LAT_ADDR = 32'h0F00_0D0C;
    localparam logic [31:0] MAILBOX_BASE_ADDR = 32'h0F00_0D10;
    localparam logic [31:0] WINDOW1_BASE_ADDR = 32'h0F00_0D14;
    localparam logic [31:0] WINDOW2_BASE_ADDR = 32'h0F00_0D18;

    // Status field positions in the command/status word.
    localparam int DPE_POS = 31;
    localparam int SSE_POS = 30;
    localparam int RMA_POS = 29;
    localparam int RTA_POS = 28;
    localparam int STA_POS = 27;
    localparam int DEVSEL_LSB = 25;
    localparam int DPR_POS = 24;

    // Command field positions.
    localparam int SYS_ERROR_REPORT_ENABLE_POS = 8;
    localparam int PER_POS = 6;
    localparam int BUS_MASTER_ENABLE_POS = 2;
    localparam int MEMORY_DECODE_ENABLE_POS = 1;
    localparam int IO_DECODE_ENABLE_POS = 0;

    // Fixed read values and writable bit masks.
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [7:0] BASE_CLASS_BRIDGE = 8'h06;
    localparam logic [7:0] SUB_CLASS_VALUE = 8'h00;
    localparam logic [7:0] IFACE_CODE_VALUE = 8'h00;
    localparam logic [7:0] CACHE_LINE_VALUE = 8'h04;
    localparam logic [31:0] CMD_WRITABLE = 32'h0000_0147;
    localparam logic [31:0] LAT_WRITABLE = 32'h0000_F800;
    localparam logic [31:0] MAILBOX_WRITABLE = 32'hFFFF_F800;
    localparam logic [3:0] MAILBOX_LOW_BITS = 4'h0;
    localparam logic [3:0] WINDOW_LOW_BITS = 4'h8;
    localparam int WINDOW_BASE_LSB = 21;
    localparam int EVENT_COUNT = 6;

    // Reset values of the stored words.
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [31:0] LAT_RESET = 32'h0000_0000;
    localparam logic [31:0] MAILBOX_RESET = 32'h0000_0000;
    localparam logic [10:0] WINDOW_RESET = 11'h000;

    // Register access request from the internal I/O space.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pbr_reg_req_t;

    // Bus event flags, most significant first.
    typedef struct packed {
        logic parity_err_detected_flag;
        logic sys_err_signalled_flag;
        logic master_abort_received_flag;
        logic target_abort_received_flag;
        logic target_abort_signalled_flag;
        logic data_parity_reported_flag;
    } pbr_events_t;

    // Command enables seen by the bus logic.
    typedef struct packed {
        logic sys_error_report_enable;
        logic parity_response_enable;
        logic bus_master_enable;
        logic memory_decode_enable;
        logic io_decode_enable;
    } pbr_cmd_t;

    // Expands byte enables into a bit mask.
    function automatic logic [31:0] pbr_byte_mask(input logic [3:0] be);
        pbr_byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : pbr_byte_mask

    // Updates the writable, enabled bits of a stored word.
    function automatic logic [31:0] pbr_merge(input logic [31:0] old_word,
        input logic [31:0] new_word, input logic [3:0] be, input logic [31:0] writable);
        logic [31:0] m;
        m = pbr_byte_mask(be) & writable;
        pbr_merge = (old_word & ~m) | (new_word & m);
    endfunction : pbr_merge

endpackage : pbr_pkg

// File: pbr_sticky_flags.sv
`timescale 1ns/100ps
// Sticky event flags: set by hardware, cleared by a one from software.
module pbr_sticky_flags #(
    parameter int WIDTH = 6
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flags_o
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } pbr_flag_state_t;

    pbr_flag_state_t r;
    pbr_flag_state_t next_r;

    // A set arriving with a clear wins, so no event is lost.
    always_comb
    begin
        next_r = r;
        next_r.flags = (r.flags & ~clr_i) | set_i;
    end

    // State register.
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign flags_o = r.flags;

    property p_set_wins;
        @(posedge sys_clk_i) disable iff (reset_i)
        (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event lost on clear.");

endmodule : pbr_sticky_flags

// File: pbr_window_base.sv
`timescale 1ns/100ps
// Target window base address with the size taken from a mask field.
module pbr_window_base (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    input wire logic [6:0] mask_i,
    output logic [31:0] base_o
);

    typedef struct packed {
        logic [10:0] hi;
    } pbr_win_state_t;

    pbr_win_state_t r;
    pbr_win_state_t next_r;
    logic [31:0] lanes_all;
    logic [10:0] lane;
    logic [10:0] cand;

    // Bits 27:21 take the written value ANDed with the mask at write time.
    always_comb
    begin
        next_r = r;
        lanes_all = pbr_pkg::pbr_byte_mask(be_i);
        lane = lanes_all[31:pbr_pkg::WINDOW_BASE_LSB];
        cand = wdata_i[31:pbr_pkg::WINDOW_BASE_LSB] & {4'hF, mask_i};
        if (wr_i)
        begin
            next_r.hi = (r.hi & ~lane) | (cand & lane);
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '{hi: pbr_pkg::WINDOW_RESET};
        end
        else
        begin
            r <= next_r;
        end
    end

    // Low address bits are wired to zero; prefetch, type and space bits fixed.
    assign base_o = {r.hi, 17'h0_0000, pbr_pkg::WINDOW_LOW_BITS};

    property p_mask_and;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && be_i[3]) |=> (base_o[27:24] == $past(wdata_i[27:24] & mask_i[6:3]));
    endproperty
    a_mask_and: assert property (p_mask_and) else $error("Window bits not masked.");

endmodule : pbr_window_base

// File: pbr_bus_agent_model.sv
`timescale 1ns/100ps
// Behavioural model of the other bus agents, which report bus events as one-cycle pulses.
module pbr_bus_agent_model (
    input wire logic sys_clk_i,
    output logic parity_err_o,
    output logic master_abort_o,
    output logic target_abort_rx_o,
    output logic target_abort_tx_o,
    output logic perr_observed_o
);
    logic [4:0] ev = 5'h00;

    // Event lines in the order parity error, master abort, abort received, abort sent, parity seen.
    assign {parity_err_o, master_abort_o, target_abort_rx_o, target_abort_tx_o, perr_observed_o} = ev;

    // Raises one event line for a single cycle; lines change just after the rising edge.
    task pulse(input int idx);
        @(posedge sys_clk_i);
        #1 ev[4 - idx] = 1'h1;
        @(posedge sys_clk_i);
        #1 ev = 5'h00;
    endtask : pulse
endmodule : pbr_bus_agent_model

// File: pbr_config_header_test.sv
`timescale 1ns/100ps
// Register-level test of the configuration header bank through its internal access port.
module pbr_config_header_test;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary value.
    localparam logic [31:0] DV = 32'(pbr_pkg::DEVSEL_MEDIUM) << pbr_pkg::DEVSEL_LSB;
    localparam int EV_POS [5] = '{pbr_pkg::DPE_POS, pbr_pkg::RMA_POS, pbr_pkg::RTA_POS,
        pbr_pkg::STA_POS, pbr_pkg::DPR_POS};
    localparam logic [31:0] CS = pbr_pkg::CMD_STATUS_ADDR;
    localparam logic [31:0] W1A = pbr_pkg::WINDOW1_BASE_ADDR;
    localparam logic [31:0] NOREG = 32'h0F00_0D00;
    logic sys_clk;
    logic reset;
    pbr_pkg::pbr_reg_req_t req;
    pbr_pkg::pbr_cmd_t cmd;
    logic [31:0] rdata, mb, w1, w2, d;
    logic rvalid, serr_req, serr_drv, perr_drv, pe, ma, tar, tat, po;
    logic [6:0] mask1, mask2;
    int fail_count = 0;
    int checks_done = 0;

    pbr_config_header #(.REVISION_CODE(REV)) i_pbr_config_header (
        .sys_clk_i(sys_clk), .reset_i(reset), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .parity_err_i(pe), .serr_request_i(serr_req),
        .master_abort_i(ma), .target_abort_rx_i(tar), .target_abort_tx_i(tat),
        .perr_observed_i(po), .window1_mask_i(mask1), .window2_mask_i(mask2), .cmd_o(cmd),
        .serr_drive_o(serr_drv), .perr_drive_o(perr_drv), .mailbox_base_o(mb),
        .window1_base_o(w1), .window2_base_o(w2));

    pbr_bus_agent_model i_pbr_bus_agent_model (
        .sys_clk_i(sys_clk), .parity_err_o(pe), .master_abort_o(ma),
        .target_abort_rx_o(tar), .target_abort_tx_o(tat), .perr_observed_o(po));

    // Compares a seen value with the expected one and reports any difference.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe with address, lanes and data.
    task wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] v);
        @(posedge sys_clk);
        #1 req = '{wr: 1'h1, rd: 1'h0, addr: a, be: be, wdata: v};
        @(posedge sys_clk);
        #1 req = '0;
    endtask : wr

    // One-cycle read strobe; the answer is taken in the cycle after the strobe.
    task rc(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        #1 req = '{wr: 1'h0, rd: 1'h1, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge sys_clk);
        #1 req = '0;
        check({31'h0, rvalid}, 32'h1);
        check(rdata, exp);
    endtask : rc

    // Request of the system-error pin for one cycle, then the registered drive is looked at.
    task pulse_serr(input logic exp);
        @(posedge sys_clk);
        #1 serr_req = 1'h1;
        @(posedge sys_clk);
        #1 serr_req = 1'h0;
        check({31'h0, serr_drv}, {31'h0, exp});
    endtask : pulse_serr

    // Prints the verdict and ends the run.
    task tally_and_finish;
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Free-running clock of 4 ns.
    initial
    begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Watchdog against a hung handshake.
    initial
    begin
        #8000;
        fail_count++;
        tally_and_finish;
    end

    // Main sequence of register accesses and bus events.
    initial
    begin
        reset = 1'h1;
        req = '0;
        serr_req = 1'h0;
        mask1 = 7'h00;
        mask2 = 7'h00;
        repeat (3) @(posedge sys_clk);
        #1 reset = 1'h0;
        rc(CS, DV);
        rc(pbr_pkg::REV_CLASS_ADDR, {pbr_pkg::BASE_CLASS_BRIDGE, 16'h0000, REV});
        rc(pbr_pkg::LINE_LAT_ADDR, {24'h0, pbr_pkg::CACHE_LINE_VALUE});
        rc(pbr_pkg::MAILBOX_BASE_ADDR, 32'h0000_0000);
        rc(W1A, 32'h0000_0008);
        rc(pbr_pkg::WINDOW2_BASE_ADDR, 32'h0000_0008);
        rc(NOREG, 32'h0000_0000);
        mask1 = 7'h55;
        mask2 = 7'h2A;
        wr(pbr_pkg::REV_CLASS_ADDR, 4'hF, 32'hFFFF_FFFF);
        rc(pbr_pkg::REV_CLASS_ADDR, {pbr_pkg::BASE_CLASS_BRIDGE, 16'h0000, REV});
        wr(pbr_pkg::LINE_LAT_ADDR, 4'hF, 32'h0000_FFFF);
        rc(pbr_pkg::LINE_LAT_ADDR, 32'h0000_F804);
        wr(pbr_pkg::MAILBOX_BASE_ADDR, 4'hF, 32'hFFFF_FFFF);
        rc(pbr_pkg::MAILBOX_BASE_ADDR, 32'hFFFF_F800);
        check(mb, 32'hFFFF_F800);
        wr(W1A, 4'hF, 32'hFFFF_FFFF);
        rc(W1A, 32'hFAA0_0008);
        wr(pbr_pkg::WINDOW2_BASE_ADDR, 4'hF, 32'hFFFF_FFFF);
        rc(pbr_pkg::WINDOW2_BASE_ADDR, 32'hF540_0008);
        mask1 = 7'h00;
        rc(W1A, 32'hFAA0_0008);
        check(w2, 32'hF540_0008);
        wr(W1A, 4'h8, 32'h0000_0000);
        rc(W1A, 32'h00A0_0008);
        check(w1, 32'h00A0_0008);
        wr(NOREG, 4'hF, 32'hFFFF_FFFF);
        rc(NOREG, 32'h0000_0000);
        // Each bus event with all enables off, then cleared by a one.
        for (int i = 0; i < 5; i++)
        begin
            i_pbr_bus_agent_model.pulse(i);
            check({31'h0, perr_drv}, 32'h0);
            rc(CS, DV | (32'h1 << EV_POS[i]));
            wr(CS, 4'h8, 32'h1 << EV_POS[i]);
            rc(CS, DV);
        end
        wr(CS, 4'h8, 32'hFF00_0000);
        rc(CS, DV);
        i_pbr_bus_agent_model.pulse(1);
        i_pbr_bus_agent_model.pulse(3);
        wr(CS, 4'h8, 32'h1 << pbr_pkg::RMA_POS);
        rc(CS, DV | (32'h1 << pbr_pkg::STA_POS));
        wr(CS, 4'h8, 32'h1 << pbr_pkg::STA_POS);
        pulse_serr(1'h0);
        rc(CS, DV);
        wr(CS, 4'hF, pbr_pkg::CMD_WRITABLE);
        check({27'h0, cmd}, 32'h0000_001F);
        pulse_serr(1'h1);
        rc(CS, DV | pbr_pkg::CMD_WRITABLE | (32'h1 << pbr_pkg::SSE_POS));
        i_pbr_bus_agent_model.pulse(0);
        check({31'h0, perr_drv}, 32'h1);
        rc(CS, DV | 32'h8100_0147 | (32'h1 << pbr_pkg::SSE_POS));
        wr(CS, 4'hF, 32'hC100_0147);
        rc(CS, DV | pbr_pkg::CMD_WRITABLE);
        wr(CS, 4'h3, 32'h0000_0000);
        check({27'h0, cmd}, 32'h0000_0000);
        tally_and_finish;
    end
endmodule : pbr_config_header_test
